// ### verilog/cam_follow_pkg.sv
// constants for the cam-following sequencer and mark compensation
// assumes a single 100 MHz clock domain
package cam_follow_pkg;
  localparam logic [15:0] CONTROL_INPUT_ADDR = 16'h2D02;
  localparam logic [15:0] CONTROL_OUTPUT_ADDR = 16'h2D12;
  localparam logic [15:0] CAM_NUMBER_ADDR = 16'h2D80;
  localparam int FOLLOW_BIT = 5;
  localparam int POS_W = 32;
  localparam int PROFILE_W = 4;
  localparam int PROFILE_DEPTH = 256;
  localparam int PROFILE_AW = 8;
  localparam logic [POS_W-1:0] CYCLE_POS_RESET = 32'h0000_0000;
  localparam logic [15:0] CONTROL_INPUT_RESET = 16'h0000;
  localparam logic [15:0] CAM_NUMBER_RESET = 16'h0000;
  localparam logic [1:0] MAIN_SEL_OWN_COMMAND = 2'h1;
  localparam logic POS_METHOD_ABSOLUTE = 1'b0;
  localparam int FILTER_SHIFT = 4;
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_FOLLOW = 2'b01
  } follow_state_e;
endpackage

// ### verilog/cam_profile_mem.sv
// cam profile table: one driven position per cycle-position bucket
// assumes writes come from the host while following is idle
`timescale 1ns/1ns
module cam_profile_mem
  import cam_follow_pkg::*;
(
  input wire logic ref_clk,
  input wire logic writeEn,
  input wire logic [PROFILE_AW-1:0] writeAddr,
  input wire logic [POS_W-1:0] writeData,
  input wire logic [PROFILE_AW-1:0] readAddr,
  output logic [POS_W-1:0] readData
);
  logic [POS_W-1:0] mem [PROFILE_DEPTH];

  // no reset: contents are loaded by the host before use
  always_ff @(posedge ref_clk) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule

// ### verilog/cam_sync_mark_compensation.sv
// cam-following sequencer with registration-mark phase compensation
// assumes host pins are asynchronous and the serial port is synchronous
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module cam_sync_mark_compensation
  import cam_follow_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cam_follow_request,
  input wire logic servo_on_input,
  input wire logic mark_compensation_request,
  input wire logic [PROFILE_W-1:0] profile_select,
  input wire logic useSerialSelect,
  input wire logic pointTableStarted,
  input wire logic [1:0] mainInputSelect,
  input wire logic positionMethod,
  input wire logic [POS_W-1:0] encoderPosition,
  input wire logic [POS_W-1:0] ownCommandPosition,
  input wire logic [POS_W-1:0] pointTargetPosition,
  input wire logic [POS_W-1:0] cycleLength,
  input wire logic [POS_W-1:0] mark_target_position,
  input wire logic [7:0] compensationTimeConstant,
  input wire logic profileWriteEn,
  input wire logic [PROFILE_AW-1:0] profileWriteAddr,
  input wire logic [POS_W-1:0] profileWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWriteData,
  output logic [15:0] regReadData,
  output logic in_cam_follow_status,
  output logic [POS_W-1:0] drivenPosition,
  output logic [POS_W-1:0] commandPosition,
  output logic [POS_W-1:0] effectiveCycleLength
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [PROFILE_W-1:0] selA;
  logic [PROFILE_W-1:0] selB;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      selA <= 4'h0;
      selB <= 4'h0;
    end else begin
      syncA <= {cam_follow_request, servo_on_input,
                mark_compensation_request};
      syncB <= syncA;
      selA <= profile_select;
      selB <= selA;
    end
  end
  logic followPin;
  logic servoOn;
  logic markPin;
  assign followPin = syncB[2];
  assign servoOn = syncB[1];
  assign markPin = syncB[0];

  ////////////////////////////////////////////////////////////////////////
  // serial registers
  logic [15:0] controlInput;
  logic [15:0] camNumber;
  logic [15:0] next_controlInput;
  logic [15:0] next_camNumber;
  logic [15:0] next_regReadData;
  logic [15:0] controlOutput;

  always_comb begin
    controlOutput = 16'h0000;
    controlOutput[FOLLOW_BIT] = in_cam_follow_status;
  end

  always_comb begin
    next_controlInput = controlInput;
    next_camNumber = camNumber;
    next_regReadData = regReadData;
    if (regWrite) begin
      if (regAddr == CONTROL_INPUT_ADDR) begin
        next_controlInput = regWriteData;
      end
      if (regAddr == CAM_NUMBER_ADDR) begin
        next_camNumber = regWriteData;
      end
    end
    if (regRead) begin
      case (regAddr)
        CONTROL_INPUT_ADDR: next_regReadData = controlInput;
        CONTROL_OUTPUT_ADDR: next_regReadData = controlOutput;
        CAM_NUMBER_ADDR: next_regReadData = camNumber;
        default: next_regReadData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      controlInput <= CONTROL_INPUT_RESET;
      camNumber <= CAM_NUMBER_RESET;
      regReadData <= 16'h0000;
    end else begin
      controlInput <= next_controlInput;
      camNumber <= next_camNumber;
      regReadData <= next_regReadData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // follow request edge and state
  logic followReq;
  logic followReqQ;
  logic markQ;
  assign followReq = followPin | controlInput[FOLLOW_BIT];

  follow_state_e state;
  follow_state_e next_state;
  logic [PROFILE_W-1:0] activeProfile;
  logic [PROFILE_W-1:0] next_activeProfile;
  logic followEdge;
  // level alone never starts following
  assign followEdge = followReq & ~followReqQ;

  always_comb begin
    next_state = state;
    next_activeProfile = activeProfile;
    case (state)
      ST_NORMAL: begin
        if (followEdge && servoOn && !pointTableStarted) begin
          next_state = ST_FOLLOW;
          next_activeProfile = useSerialSelect ?
            camNumber[PROFILE_W-1:0] : selB;
        end
      end
      ST_FOLLOW: begin
        // dropping the request or servo leaves cam control
        if (!followReq || !servoOn) begin
          next_state = ST_NORMAL;
        end
      end
      default: next_state = ST_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_NORMAL;
      activeProfile <= 4'h0;
      followReqQ <= 1'b0;
      markQ <= 1'b0;
      in_cam_follow_status <= 1'b0;
    end else begin
      state <= next_state;
      activeProfile <= next_activeProfile;
      followReqQ <= followReq;
      markQ <= markPin;
      in_cam_follow_status <= (next_state == ST_FOLLOW);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // master position and cycle position
  logic [POS_W-1:0] masterPos;
  logic [POS_W-1:0] masterPrev;
  logic [POS_W-1:0] cyclePos;
  logic [POS_W-1:0] next_cyclePos;
  logic [POS_W-1:0] pendingShift;
  logic [POS_W-1:0] next_pendingShift;
  logic shiftUp;
  logic next_shiftUp;
  logic [POS_W-1:0] latchedPos;
  logic [POS_W-1:0] next_latchedPos;
  logic [POS_W-1:0] next_effLen;
  logic [POS_W-1:0] delta;
  logic [POS_W-1:0] step;
  logic [POS_W-1:0] advanced;
  logic markEdge;

  assign masterPos = (mainInputSelect == MAIN_SEL_OWN_COMMAND) ?
    commandPosition : encoderPosition;
  assign delta = masterPos - masterPrev;
  assign markEdge = markPin & ~markQ;

  // filtered step is a fraction of the remaining shift
  always_comb begin
    if (compensationTimeConstant == 8'h00) begin
      step = pendingShift;
    end else begin
      step = pendingShift >> FILTER_SHIFT;
      if (step == '0 && pendingShift != '0) begin
        step = 32'h0000_0001;
      end
    end
  end

  always_comb begin
    next_cyclePos = cyclePos;
    next_pendingShift = pendingShift;
    next_shiftUp = shiftUp;
    next_latchedPos = latchedPos;
    next_effLen = effectiveCycleLength;
    advanced = cyclePos + delta;
    if (state == ST_FOLLOW) begin
      advanced = shiftUp ? advanced + step : advanced - step;
      next_pendingShift = pendingShift - step;
      // wrap keeps the cycle position inside one sheet length
      if (advanced >= cycleLength && cycleLength != '0) begin
        advanced = advanced - cycleLength;
        next_effLen = cycleLength;
      end
      next_cyclePos = advanced;
      if (markEdge) begin
        next_latchedPos = cyclePos;
        if (mark_target_position >= cyclePos) begin
          next_pendingShift = mark_target_position - cyclePos;
          next_shiftUp = 1'b1;
          next_effLen = cycleLength - next_pendingShift;
        end else begin
          next_pendingShift = cyclePos - mark_target_position;
          next_shiftUp = 1'b0;
          next_effLen = cycleLength + next_pendingShift;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cyclePos <= CYCLE_POS_RESET;
      masterPrev <= CYCLE_POS_RESET;
      pendingShift <= '0;
      shiftUp <= 1'b0;
      latchedPos <= '0;
      effectiveCycleLength <= '0;
    end else begin
      cyclePos <= next_cyclePos;
      masterPrev <= masterPos;
      pendingShift <= next_pendingShift;
      shiftUp <= next_shiftUp;
      latchedPos <= next_latchedPos;
      effectiveCycleLength <= next_effLen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // own command position and profile lookup
  logic [POS_W-1:0] next_commandPosition;
  always_comb begin
    if (positionMethod == POS_METHOD_ABSOLUTE) begin
      next_commandPosition = pointTargetPosition;
    end else begin
      next_commandPosition = commandPosition + pointTargetPosition;
    end
  end

  logic [POS_W-1:0] profileData;
  logic [PROFILE_AW-1:0] lookupAddr;
  // upper four address bits pick the profile, lower four the segment
  assign lookupAddr = {activeProfile, cyclePos[POS_W-1 -: 4]};

  cam_profile_mem profileMem (
    .ref_clk(ref_clk),
    .writeEn(profileWriteEn),
    .writeAddr(profileWriteAddr),
    .writeData(profileWriteData),
    .readAddr(lookupAddr),
    .readData(profileData)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      commandPosition <= '0;
      drivenPosition <= '0;
    end else begin
      commandPosition <= next_commandPosition;
      if (state == ST_FOLLOW) begin
        drivenPosition <= profileData;
      end
    end
  end
endmodule

// ### sim/cam_sync_mark_compensation_asserts.sv
// checker: port-level properties of the cam follow block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/1ns
module cam_sync_mark_compensation_asserts
  import cam_follow_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cam_follow_request,
  input wire logic servo_on_input,
  input wire logic pointTableStarted,
  input wire logic positionMethod,
  input wire logic [POS_W-1:0] pointTargetPosition,
  input wire logic regRead,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regReadData,
  input wire logic in_cam_follow_status,
  input wire logic [POS_W-1:0] drivenPosition,
  input wire logic [POS_W-1:0] commandPosition
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // servo pins pass two sync stages, so allow four cycles
  property p_drop; !servo_on_input[*4] |=> !in_cam_follow_status;
  endproperty
  a_drop: assert property (p_drop)
    else $error("follow kept with servo off");
  property p_block; $rose(in_cam_follow_status) |-> !$past(pointTableStarted);
  endproperty
  a_block: assert property (p_block)
    else $error("follow entered during point table run");
  property p_level;
    cam_follow_request[*6] ##0 !in_cam_follow_status |=> !in_cam_follow_status;
  endproperty
  a_level: assert property (p_level)
    else $error("held request level started following");
  // status one cycle on follows pin levels two samples back
  property p_hold; in_cam_follow_status && $past(servo_on_input, 2)
    && $past(cam_follow_request, 2) |=> in_cam_follow_status;
  endproperty
  a_hold: assert property (p_hold)
    else $error("following dropped while requested");
  property p_stat; regRead && regAddr == CONTROL_OUTPUT_ADDR
    |=> regReadData == {10'h000, $past(in_cam_follow_status), 5'h00};
  endproperty
  a_stat: assert property (p_stat)
    else $error("status word does not show following");
  property p_unmap; regRead && regAddr != CONTROL_INPUT_ADDR
    && regAddr != CONTROL_OUTPUT_ADDR && regAddr != CAM_NUMBER_ADDR
    |=> regReadData == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_reset; $rose(rst_b) |-> !in_cam_follow_status
    && drivenPosition == 32'h0000_0000 && commandPosition == 32'h0000_0000;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not zero after reset");
  property p_abs; pointTableStarted && !positionMethod
    |=> commandPosition == $past(pointTargetPosition);
  endproperty
  a_abs: assert property (p_abs)
    else $error("absolute command not taken");
endmodule
bind cam_sync_mark_compensation cam_sync_mark_compensation_asserts u_chk (
  .ref_clk, .rst_b, .cam_follow_request, .servo_on_input, .pointTableStarted,
  .positionMethod, .pointTargetPosition, .regRead, .regAddr, .regReadData,
  .in_cam_follow_status, .drivenPosition, .commandPosition);

// ### sim/cam_host_model.sv
// host controller model: command pins and the mark sensor
// assumes the bench calls its tasks; pins change on falling edges
`timescale 1ns/1ns
module cam_host_model
  import cam_follow_pkg::*;
(
  input wire logic ref_clk,
  input wire logic in_cam_follow_status,
  output logic cam_follow_request,
  output logic servo_on_input,
  output logic mark_compensation_request,
  output logic [PROFILE_W-1:0] profile_select
);
  initial begin
    {cam_follow_request, servo_on_input, mark_compensation_request} = '0;
    profile_select = 4'h0;
  end
  ////////////////////////////////////////
  task automatic pins(input logic r, s);
    @(negedge ref_clk);
    {cam_follow_request, servo_on_input} = {r, s};
  endtask
  // cam first, then servo, then the request edge
  task automatic start_follow(input logic [PROFILE_W-1:0] cam);
    @(negedge ref_clk);
    profile_select = cam;
    pins(1'b0, 1'b1);
    repeat (4) @(negedge ref_clk);
    pins(1'b1, 1'b1);
  endtask
  // long pulse: the block must still compensate once only
  task automatic pulse_mark;
    pins(cam_follow_request, servo_on_input);
    mark_compensation_request = 1'b1;
    repeat (6) @(negedge ref_clk);
    mark_compensation_request = 1'b0;
  endtask
endmodule

// ### sim/cam_sync_mark_compensation_tb_top.sv
// self-checking bench for the cam follow block and mark compensation
// assumes package, checker and host model are compiled first
`timescale 1ns/1ns
module cam_sync_mark_compensation_tb_top;
  import cam_follow_pkg::*;
  logic ref_clk, rst_b, useSerialSelect, pointTableStarted, positionMethod;
  logic profileWriteEn, regWrite, regRead, in_cam_follow_status;
  logic cam_follow_request, servo_on_input, mark_compensation_request;
  logic [PROFILE_W-1:0] profile_select;
  logic [1:0] mainInputSelect;
  logic [7:0] compensationTimeConstant;
  logic [PROFILE_AW-1:0] profileWriteAddr;
  logic [15:0] regAddr, regWriteData, regReadData, d;
  logic [POS_W-1:0] encoderPosition, ownCommandPosition, pointTargetPosition;
  logic [POS_W-1:0] cycleLength, mark_target_position, profileWriteData;
  logic [POS_W-1:0] drivenPosition, commandPosition, effectiveCycleLength;
  logic [POS_W-1:0] len, tgt;
  int errTotal = 0;
  int nCompared = 0;
  int seed = 18;
  cam_sync_mark_compensation dut (.ref_clk, .rst_b, .cam_follow_request,
    .servo_on_input, .mark_compensation_request, .profile_select,
    .useSerialSelect, .pointTableStarted, .mainInputSelect, .positionMethod,
    .encoderPosition, .ownCommandPosition, .pointTargetPosition, .cycleLength,
    .mark_target_position, .compensationTimeConstant, .profileWriteEn,
    .profileWriteAddr, .profileWriteData, .regWrite, .regRead, .regAddr,
    .regWriteData, .regReadData, .in_cam_follow_status, .drivenPosition,
    .commandPosition, .effectiveCycleLength);
  cam_host_model host (.ref_clk, .in_cam_follow_status, .cam_follow_request,
    .servo_on_input, .mark_compensation_request, .profile_select);
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_acc(input logic wr, input logic [15:0] a, dat);
    @(negedge ref_clk);
    {regWrite, regRead, regAddr, regWriteData} = {wr, !wr, a, dat};
    @(negedge ref_clk);
    {regWrite, regRead} = 2'b00;
  endtask
  task automatic rd_chk(input logic [15:0] a, e);
    reg_acc(1'b0, a, 16'h0000);
    chk({16'h0000, regReadData}, {16'h0000, e});
  endtask
  task automatic wait_stat(input logic v);
    for (int n = 0; n < 20 && in_cam_follow_status !== v; n++)
      @(negedge ref_clk);
    chk({31'h0, in_cam_follow_status}, {31'h0, v});
  endtask
  task automatic wait_len(input logic [31:0] e);
    for (int n = 0; n < 300 && effectiveCycleLength !== e; n++)
      @(negedge ref_clk);
    chk(effectiveCycleLength, e);
  endtask
  function automatic logic [31:0] exp_len(input logic [31:0] l, c, t);
    return (t >= c) ? l - (t - c) : l + (c - t);
  endfunction
  task automatic close_out;
    $display("compared %0d mismatched %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #50000;
    errTotal++;
    close_out;
  end
  initial begin
    ref_clk = 1'b0;
    {rst_b, useSerialSelect, pointTableStarted, positionMethod} = 4'h0;
    {profileWriteEn, regWrite, regRead, regAddr, regWriteData} = '0;
    {encoderPosition, ownCommandPosition, profileWriteAddr} = '0;
    {compensationTimeConstant, profileWriteData} = '0;
    mainInputSelect = MAIN_SEL_OWN_COMMAND;
    len = 32'h0000_1000 + ($random(seed) & 32'h0000_0FFF);
    tgt = len >> 1;
    {cycleLength, mark_target_position} = {len, tgt};
    pointTargetPosition = $random(seed);
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    rd_chk(CONTROL_INPUT_ADDR, CONTROL_INPUT_RESET);
    rd_chk(CONTROL_OUTPUT_ADDR, 16'h0000);
    reg_acc(1'b1, 16'h1234, 16'hFFFF);
    rd_chk(16'h1234, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed)) & 16'h000F;
      reg_acc(1'b1, CAM_NUMBER_ADDR, d);
      rd_chk(CAM_NUMBER_ADDR, d);
    end
    @(negedge ref_clk);
    {profileWriteEn, profileWriteAddr, profileWriteData} = {1'b1, 8'h20, len};
    @(negedge ref_clk);
    {profileWriteAddr, profileWriteData} = {8'h30, ~len};
    @(negedge ref_clk);
    {profileWriteEn, pointTableStarted} = 2'b01;
    repeat (3) @(negedge ref_clk);
    chk(commandPosition, pointTargetPosition);
    host.pins(1'b1, 1'b1);
    repeat (10) @(negedge ref_clk);
    wait_stat(1'b0);
    host.pins(1'b0, 1'b0);
    {pointTableStarted, pointTargetPosition} = '0;
    host.pins(1'b1, 1'b0);
    repeat (10) @(negedge ref_clk);
    wait_stat(1'b0);
    host.pins(1'b0, 1'b0);
    host.start_follow(4'h2);
    wait_stat(1'b1);
    rd_chk(CONTROL_OUTPUT_ADDR, 16'h0020);
    chk(drivenPosition, len);
    host.pulse_mark;
    wait_len(exp_len(len, 32'h0, tgt));
    {mark_target_position, compensationTimeConstant} = {tgt >> 1, 8'h03};
    host.pulse_mark;
    wait_len(exp_len(len, tgt, tgt >> 1));
    // filter must finish the whole shift before the next mark
    repeat (300) @(negedge ref_clk);
    mark_target_position = tgt;
    host.pulse_mark;
    wait_len(exp_len(len, tgt >> 1, tgt));
    host.pins(1'b1, 1'b0);
    wait_stat(1'b0);
    host.pins(1'b1, 1'b1);
    repeat (10) @(negedge ref_clk);
    wait_stat(1'b0);
    host.pins(1'b0, 1'b1);
    useSerialSelect = 1'b1;
    // pin fall must reach the edge detector before the serial bit rises
    repeat (4) @(negedge ref_clk);
    reg_acc(1'b1, CAM_NUMBER_ADDR, 16'h0003);
    reg_acc(1'b1, CONTROL_INPUT_ADDR, 16'h0020);
    wait_stat(1'b1);
    rd_chk(CONTROL_INPUT_ADDR, 16'h0020);
    chk(drivenPosition, ~len);
    reg_acc(1'b1, CONTROL_INPUT_ADDR, 16'h0000);
    wait_stat(1'b0);
    close_out;
  end
endmodule
